//--- hdl/spectral_avg_regs.v
// Averaging count, supply reading and buffer index registers behind the serial port
`timescale 1ns/100ps
//
// Contract
// RULE1: In manual, automatic and time capture modes, supply is sampled per capture.
// RULE2: Supply register reads 0x8000 until first capture completes; read-only.
// RULE3: Supply reading is unsigned in bits 11:0; bits 15:12 read zero.
// RULE4: Default counts: rate zero averages eight records, rate one uses one.
// RULE5: Capture block, transform, accumulate until count reached, then average all.
// RULE6: Supply and temperature sampled after each block and accumulated.
// RULE7: First count register: rate one in 15:8, rate zero in 7:0.
// RULE8: Second count register: rate three in 15:8, rate two in 7:0; reset 0x0101.
// RULE9: Host writes 16-bit registers as two byte writes, low address first.
// RULE10: Index clears at each capture end; advances on each output data read.
// RULE11: Index at mode maximum wraps to zero on next read increment.
// RULE12: Index spans 0..2047 in spectrum modes, 0..4095 in time capture.
// RULE13: Host writes index in bits 11:0, bits 15:12 zero.
// RULE14: Writing the index loads that buffered sample into the output data register.
// RULE15: Mode bits: 00 manual spectrum, 01 automatic spectrum, 10 time capture.
// RULE16: A zero count is treated as a single record.
`include "spectral_avg_defs.vh"

module spectral_avg_regs #(
    parameter IDX_W = 12,
    parameter SUM_W = 24
) (
    input wire core_clk,
    input wire rst,
    input wire sclk,
    input wire cs_n,
    input wire din,
    output reg dout,
    output reg dout_oe,
    input wire [1:0] mode,
    input wire [1:0] rate_selection,
    input wire cap_start,
    input wire cap_done,
    input wire blk_done,
    input wire fft_done,
    input wire [11:0] supply_code,
    input wire [15:0] temp_code,
    input wire [15:0] buf_rdata,
    output reg [IDX_W-1:0] buf_index,
    output reg blk_go,
    output reg fft_go,
    output reg fft_acc,
    output reg avg_go,
    output reg [7:0] avg_count,
    output reg [15:0] temp_avg,
    output reg busy
);

    localparam ST_IDLE = 3'd0;
    localparam ST_BLK = 3'd1;
    localparam ST_FFT = 3'd2;
    localparam ST_DIV = 3'd3;
    localparam ST_TIME = 3'd4;

    // One restoring division step: returns {remainder, quotient bit}
    function [9:0] div_step;
        input [8:0] rem;
        input nb;
        input [7:0] d;
        reg [8:0] t;
        begin
            t = {rem[7:0], nb};
            if (t >= {1'b0, d}) begin
                div_step = {t - {1'b0, d}, 1'b1};
            end else begin
                div_step = {t, 1'b0};
            end
        end
    endfunction

    // Record count for the selected rate, zero promoted to one
    function [7:0] pick_count;
        input [1:0] r;
        input [15:0] lo;
        input [15:0] hi;
        reg [7:0] c;
        begin
            case (r)
                2'd0: c = lo[7:0];
                2'd1: c = lo[15:8];
                2'd2: c = hi[7:0];
                default: c = hi[15:8];
            endcase
            pick_count = (c == 8'h00) ? 8'h01 : c;
        end
    endfunction

    // Pin synchronisers; the first stage feeds only the second
    reg sclk_s1_q, sclk_s2_q, sclk_s3_q;
    reg cs_s1_q, cs_s2_q;
    reg din_s1_q, din_s2_q;

    reg [4:0] bit_cnt_q;
    reg [14:0] rx_q;
    reg [15:0] tx_q;

    reg [15:0] supply_q;
    reg [11:0] supply_pend_q;
    reg [15:0] avg_lo_q;
    reg [15:0] avg_hi_q;
    reg [15:0] out_buf_q;
    reg load_q;

    reg [2:0] st_q;
    reg [7:0] rec_q;
    reg [7:0] div_q;
    reg [4:0] step_q;
    reg [SUM_W-1:0] sup_sum_q;
    reg [SUM_W-1:0] tmp_sum_q;
    reg [8:0] sup_rem_q;
    reg [8:0] tmp_rem_q;

    wire sclk_rise = sclk_s2_q & ~sclk_s3_q;
    wire sclk_fall = ~sclk_s2_q & sclk_s3_q;
    wire frame_end = sclk_rise & ~cs_s2_q & (bit_cnt_q == `FRAME_BITS - 5'd1);
    wire [15:0] word = {rx_q, din_s2_q};
    wire is_wr = frame_end & word[15];
    wire is_rd = frame_end & ~word[15];
    wire [6:0] addr = word[14:8];
    wire [6:0] reg_addr = {addr[6:1], 1'b0};
    wire hi_byte = addr[0];

    wire [IDX_W-1:0] idx_max = (mode == `MODE_TIME) ? `IDX_MAX_TIME : `IDX_MAX_SPEC;
    wire out_read = is_rd & (reg_addr == `ADDR_OUT);
    wire [9:0] sup_step = div_step(sup_rem_q, sup_sum_q[SUM_W-1], div_q);
    wire [9:0] tmp_step = div_step(tmp_rem_q, tmp_sum_q[SUM_W-1], div_q);
    wire [7:0] rec_next = rec_q + 8'd1;

    reg [15:0] rd_val;
    always @* begin
        case (reg_addr)
            `ADDR_SUPPLY: rd_val = supply_q;
            `ADDR_AVG_LO: rd_val = avg_lo_q;
            `ADDR_AVG_HI: rd_val = avg_hi_q;
            `ADDR_INDEX: rd_val = {4'h0, buf_index};
            `ADDR_OUT: rd_val = out_buf_q;
            default: rd_val = 16'h0000;
        endcase
    end

    // Serial port: sample on rising clock, shift out on falling
    always @(posedge core_clk) begin
        sclk_s1_q <= sclk;
        sclk_s2_q <= sclk_s1_q;
        sclk_s3_q <= sclk_s2_q;
        cs_s1_q <= cs_n;
        cs_s2_q <= cs_s1_q;
        din_s1_q <= din;
        din_s2_q <= din_s1_q;
        if (rst) begin
            sclk_s1_q <= 1'b1;
            sclk_s2_q <= 1'b1;
            sclk_s3_q <= 1'b1;
            cs_s1_q <= 1'b1;
            cs_s2_q <= 1'b1;
            din_s1_q <= 1'b0;
            din_s2_q <= 1'b0;
            bit_cnt_q <= 5'd0;
            rx_q <= 15'h0000;
            tx_q <= 16'h0000;
            dout <= 1'b0;
            dout_oe <= 1'b0;
        end else begin
            dout <= tx_q[15];
            dout_oe <= ~cs_s2_q;
            if (cs_s2_q) begin
                bit_cnt_q <= 5'd0;
            end else if (sclk_rise) begin
                rx_q <= word[14:0];
                bit_cnt_q <= frame_end ? 5'd0 : bit_cnt_q + 5'd1;
            end
            // Read data goes out during the following frame
            // The first fall of a frame presents bit 15, so only later falls shift
            if (is_rd) begin
                tx_q <= rd_val;
            end else if (sclk_fall & ~cs_s2_q & (bit_cnt_q != 5'd0)) begin
                tx_q <= {tx_q[14:0], 1'b0};
            end
        end
    end

    // Register writes, index handling and averaging sequencer
    always @(posedge core_clk) begin
        if (rst) begin
            supply_q <= `RST_SUPPLY; // RULE2
            supply_pend_q <= 12'h000;
            avg_lo_q <= `RST_AVG_LO; // RULE4
            avg_hi_q <= `RST_AVG_HI; // RULE8
            out_buf_q <= `RST_OUT;
            load_q <= 1'b0;
            buf_index <= `RST_INDEX;
            st_q <= ST_IDLE;
            rec_q <= 8'h00;
            div_q <= 8'h01;
            step_q <= 5'd0;
            sup_sum_q <= {SUM_W{1'b0}};
            tmp_sum_q <= {SUM_W{1'b0}};
            sup_rem_q <= 9'h000;
            tmp_rem_q <= 9'h000;
            blk_go <= 1'b0;
            fft_go <= 1'b0;
            fft_acc <= 1'b0;
            avg_go <= 1'b0;
            avg_count <= 8'h01;
            temp_avg <= 16'h0000;
            busy <= 1'b0;
        end else begin
            blk_go <= 1'b0;
            fft_go <= 1'b0;
            fft_acc <= 1'b0;
            avg_go <= 1'b0;
            load_q <= 1'b0;
            // Buffer memory answers the index one cycle after it changes
            if (load_q) begin
                out_buf_q <= buf_rdata; // RULE14
            end
            // Byte writes; the supply register has no write path
            if (is_wr) begin
                case (reg_addr)
                    `ADDR_AVG_LO: begin
                        if (hi_byte) begin
                            avg_lo_q[15:8] <= word[7:0]; // RULE7 RULE9
                        end else begin
                            avg_lo_q[7:0] <= word[7:0]; // RULE7 RULE9
                        end
                    end
                    `ADDR_AVG_HI: begin
                        if (hi_byte) begin
                            avg_hi_q[15:8] <= word[7:0]; // RULE8
                        end else begin
                            avg_hi_q[7:0] <= word[7:0]; // RULE8
                        end
                    end
                    `ADDR_INDEX: begin
                        // Upper nibble of the high byte is dropped
                        if (hi_byte) begin
                            buf_index[11:8] <= word[3:0]; // RULE13
                        end else begin
                            buf_index[7:0] <= word[7:0];
                        end
                        load_q <= 1'b1; // RULE14
                    end
                    default: begin
                    end
                endcase
            end
            if (out_read) begin
                buf_index <= (buf_index >= idx_max) ? `RST_INDEX
                    : buf_index + 12'd1; // RULE10 RULE11 RULE12
                load_q <= 1'b1;
            end
            case (st_q)
                ST_IDLE: begin
                    if (cap_start) begin
                        busy <= 1'b1;
                        if (mode == `MODE_TIME) begin // RULE15
                            supply_pend_q <= supply_code; // RULE1
                            st_q <= ST_TIME;
                        end else if (mode != 2'b11) begin // RULE15
                            rec_q <= 8'h00;
                            div_q <= pick_count(rate_selection, avg_lo_q, avg_hi_q); // RULE16
                            sup_sum_q <= {SUM_W{1'b0}};
                            tmp_sum_q <= {SUM_W{1'b0}};
                            blk_go <= 1'b1; // RULE5
                            st_q <= ST_BLK;
                        end else begin
                            busy <= 1'b0;
                        end
                    end
                end
                ST_TIME: begin
                    if (cap_done) begin
                        supply_q <= {4'h0, supply_pend_q}; // RULE1 RULE2 RULE3
                        buf_index <= `RST_INDEX; // RULE10
                        load_q <= 1'b1;
                        busy <= 1'b0;
                        st_q <= ST_IDLE;
                    end
                end
                ST_BLK: begin
                    if (blk_done) begin
                        sup_sum_q <= sup_sum_q + {{(SUM_W-12){1'b0}}, supply_code}; // RULE6
                        tmp_sum_q <= tmp_sum_q + {{(SUM_W-16){1'b0}}, temp_code}; // RULE6
                        fft_go <= 1'b1; // RULE5
                        st_q <= ST_FFT;
                    end
                end
                ST_FFT: begin
                    if (fft_done) begin
                        fft_acc <= 1'b1; // RULE5
                        rec_q <= rec_next;
                        if (rec_next == div_q) begin
                            sup_rem_q <= 9'h000;
                            tmp_rem_q <= 9'h000;
                            step_q <= 5'd0;
                            st_q <= ST_DIV;
                        end else begin
                            blk_go <= 1'b1;
                            st_q <= ST_BLK;
                        end
                    end
                end
                ST_DIV: begin
                    // Both sums share the count, so they divide side by side
                    sup_rem_q <= sup_step[9:1];
                    tmp_rem_q <= tmp_step[9:1];
                    sup_sum_q <= {sup_sum_q[SUM_W-2:0], sup_step[0]};
                    tmp_sum_q <= {tmp_sum_q[SUM_W-2:0], tmp_step[0]};
                    step_q <= step_q + 5'd1;
                    if (step_q == `DIV_STEPS - 5'd1) begin
                        supply_q <= {4'h0, sup_sum_q[10:0], sup_step[0]}; // RULE3 RULE5
                        temp_avg <= {tmp_sum_q[14:0], tmp_step[0]}; // RULE5
                        avg_count <= div_q;
                        avg_go <= 1'b1; // RULE5
                        buf_index <= `RST_INDEX; // RULE10
                        load_q <= 1'b1;
                        busy <= 1'b0;
                        st_q <= ST_IDLE;
                    end
                end
                default: begin
                    st_q <= ST_IDLE;
                end
            endcase
        end
    end

endmodule // spectral_avg_regs

//--- hdl/spectral_avg_defs.vh
// Offsets, reset values, mode codes and counts of the averaging register group
`ifndef SPECTRAL_AVG_DEFS_VH
`define SPECTRAL_AVG_DEFS_VH

// Byte addresses on the serial port (low byte of each 16-bit register)
`define ADDR_SUPPLY 7'h04
`define ADDR_AVG_LO 7'h06
`define ADDR_AVG_HI 7'h08
`define ADDR_INDEX 7'h0a
`define ADDR_OUT 7'h12

// Reset values
`define RST_SUPPLY 16'h8000
`define RST_AVG_LO 16'h0108
`define RST_AVG_HI 16'h0101
`define RST_INDEX 12'h000
`define RST_OUT 16'h8000

// Record control mode field
`define MODE_MANUAL 2'b00
`define MODE_AUTO 2'b01
`define MODE_TIME 2'b10

// Highest buffer index per mode
`define IDX_MAX_SPEC 12'h7ff
`define IDX_MAX_TIME 12'hfff

// Serial frame length and averaging divider step count
`define FRAME_BITS 5'd16
`define DIV_STEPS 5'd24

`endif

//--- bench/spectral_avg_props.sv
// Timing checks on the capture sequencer and the buffer index
`timescale 1ns/100ps
module spectral_avg_props #(
    parameter IDX_W = 12
) (
    input wire core_clk,
    input wire rst,
    input wire [1:0] mode,
    input wire cap_start,
    input wire cap_done,
    input wire blk_done,
    input wire fft_done,
    input wire [IDX_W-1:0] buf_index,
    input wire blk_go,
    input wire fft_go,
    input wire fft_acc,
    input wire avg_go,
    input wire [7:0] avg_count,
    input wire busy
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);
    chk_capture_start: assert property (
        (cap_start && !busy && !mode[1]) |=> (blk_go && busy)) else $error("no block start");
    chk_fft_cause: assert property (
        fft_go |-> $past(blk_done)) else $error("transform without block");
    chk_acc_cause: assert property (
        fft_acc |-> $past(fft_done)) else $error("accumulate without transform");
    chk_avg_delay: assert property (
        avg_go |-> $past(fft_acc, 24)) else $error("average step count wrong");
    chk_go_single: assert property (
        blk_go |=> !blk_go) else $error("block pulse too long");
    chk_busy_span: assert property (
        (blk_go || fft_go || fft_acc) |-> busy) else $error("sequencer active while idle");
    chk_avg_clears: assert property (
        avg_go |-> (buf_index == 0 && !busy)) else $error("index not cleared at end");
    chk_time_clear: assert property (
        (cap_done && busy && mode == 2'b10) |-> ##[1:2] buf_index == 0)
        else $error("index not cleared after time capture");
    chk_zero_count: assert property (
        avg_go |-> avg_count != 8'h00) else $error("zero record count used");
endmodule // spectral_avg_props

bind spectral_avg_regs spectral_avg_props #(.IDX_W(IDX_W)) i_props (.core_clk(core_clk),
    .rst(rst), .mode(mode), .cap_start(cap_start), .cap_done(cap_done), .blk_done(blk_done),
    .fft_done(fft_done), .buf_index(buf_index), .blk_go(blk_go), .fft_go(fft_go),
    .fft_acc(fft_acc), .avg_go(avg_go), .avg_count(avg_count), .busy(busy));

//--- bench/spi_host.sv
// Serial port host that sends 16-bit frames in clock mode 3
`timescale 1ns/100ps
module spi_host (
    input wire core_clk,
    input wire dout,
    input wire dout_oe,
    output reg sclk,
    output reg cs_n,
    output reg din
);
    // A released line reads back inverted so a stale bit never passes
    reg last_q;
    wire miso = dout_oe ? dout : ~last_q;
    initial begin
        sclk = 1'b1;
        cs_n = 1'b1;
        din = 1'b0;
        last_q = 1'b0;
    end
    task half;
        repeat (8) @(negedge core_clk);
    endtask
    task xfer(input [15:0] w, output [15:0] r);
        integer i;
        begin
            cs_n = 1'b0;
            half;
            for (i = 15; i >= 0; i = i - 1) begin
                sclk = 1'b0;
                din = w[i];
                half;
                sclk = 1'b1;
                r[i] = miso;
                last_q = miso;
                half;
            end
            cs_n = 1'b1;
            din = ~din;
            half;
        end
    endtask
endmodule // spi_host

//--- bench/test_spectral_avg_regs.sv
// Self-checking bench for the averaging and buffer index registers
`timescale 1ns/100ps
module test_spectral_avg_regs;
    reg core_clk = 1'b0;
    reg rst = 1'b1;
    reg [1:0] mode = 2'b00;
    reg [1:0] rate_selection = 2'd0;
    reg cap_start = 1'b0;
    reg cap_done = 1'b0;
    reg blk_done = 1'b0;
    reg fft_done = 1'b0;
    reg [11:0] supply_code = 12'h000;
    reg [15:0] temp_code = 16'h0000;
    reg [15:0] buf_rdata = 16'h0000;
    wire sclk, cs_n, din, dout, dout_oe, blk_go, fft_go, fft_acc, avg_go, busy;
    wire [11:0] buf_index;
    wire [7:0] avg_count;
    wire [15:0] temp_avg;
    integer mismatches = 0;
    integer tests_run = 0;
    integer nblk = 0;
    integer i, t;
    reg [15:0] r;
    // Row: check flag, frame sent, answer expected during that frame
    reg [32:0] rows [0:12];
    always #20 core_clk = ~core_clk;
    spi_host i_host (.core_clk(core_clk), .dout(dout), .dout_oe(dout_oe), .sclk(sclk),
        .cs_n(cs_n), .din(din));
    spectral_avg_regs i_dut (.core_clk(core_clk), .rst(rst), .sclk(sclk), .cs_n(cs_n),
        .din(din), .dout(dout), .dout_oe(dout_oe), .mode(mode), .rate_selection(rate_selection),
        .cap_start(cap_start), .cap_done(cap_done), .blk_done(blk_done), .fft_done(fft_done),
        .supply_code(supply_code), .temp_code(temp_code), .buf_rdata(buf_rdata),
        .buf_index(buf_index), .blk_go(blk_go), .fft_go(fft_go), .fft_acc(fft_acc),
        .avg_go(avg_go), .avg_count(avg_count), .temp_avg(temp_avg), .busy(busy));
    // Capture engine and sample buffer: each block and transform go pulse is answered one cycle later
    always @(negedge core_clk) begin
        blk_done <= blk_go;
        fft_done <= fft_go;
        buf_rdata <= {4'ha, buf_index};
        if (blk_go) begin
            supply_code <= 12'h400 + nblk[11:0];
            temp_code <= 16'd100 + nblk[15:0];
            nblk <= nblk + 1;
        end
    end
    task report_and_stop;
        begin
            $display("checks %0d mismatches %0d", tests_run, mismatches);
            if (mismatches == 0 && tests_run > 0)
                $display("== PASSED ==");
            else
                $display("== FAILED ==");
            $finish;
        end
    endtask
    task check(input [8*8:1] name, input [15:0] exp, input [15:0] got);
        begin
            tests_run = tests_run + 1;
            if (got !== exp) begin
                mismatches = mismatches + 1;
                $display("MISMATCH %0s expected %h seen %h", name, exp, got);
            end
        end
    endtask
    // Answer to a read frame only arrives during the following frame
    task rd(input [15:0] cmd, output [15:0] v);
        begin
            i_host.xfer(cmd, v);
            i_host.xfer(16'h0000, v);
        end
    endtask
    task run_cap(input [1:0] sel, input [7:0] n);
        begin
            nblk = 0;
            rate_selection = sel;
            cap_start = 1'b1;
            @(negedge core_clk);
            cap_start = 1'b0;
            t = 0;
            while (avg_go !== 1'b1 && t < 5000) begin
                @(negedge core_clk);
                t = t + 1;
            end
            if (t >= 5000) begin
                mismatches = mismatches + 1;
                report_and_stop;
            end
            check("blocks", {8'h00, n}, nblk[15:0]);
            check("count", {8'h00, n}, {8'h00, avg_count});
            check("index", 16'h0000, {4'h0, buf_index});
            check("temp", 16'd100 + (n - 8'd1) / 8'd2, temp_avg);
            rd(16'h0400, r);
            check("supply", 16'h0400 + (n - 8'd1) / 8'd2, r);
        end
    endtask
    task idx(input [11:0] v, input [1:0] m, input [11:0] exp);
        begin
            mode = m;
            i_host.xfer({8'h8a, v[7:0]}, r);
            i_host.xfer({8'h8b, 4'h0, v[11:8]}, r);
            i_host.xfer(16'h1200, r);
            check("wrap", {4'h0, exp}, {4'h0, buf_index});
        end
    endtask
    initial begin
        rows[0] = 33'h0_0400_0000;
        rows[1] = 33'h1_0600_8000;
        rows[2] = 33'h1_0800_0108;
        rows[3] = 33'h1_0a00_0101;
        rows[4] = 33'h1_8401_0000;
        rows[5] = 33'h0_8601_0000;
        rows[6] = 33'h0_8703_0000;
        rows[7] = 33'h0_8800_0000;
        rows[8] = 33'h0_0400_0000;
        rows[9] = 33'h1_0600_8000;
        rows[10] = 33'h1_0800_0301;
        rows[11] = 33'h1_2000_0100;
        rows[12] = 33'h1_0000_0000;
        repeat (2) @(negedge core_clk);
        rst = 1'b0;
        repeat (4) @(negedge core_clk);
        for (i = 0; i < 13; i = i + 1) begin
            i_host.xfer(rows[i][31:16], r);
            if (rows[i][32]) check("row", rows[i][15:0], r);
        end
        run_cap(2'd1, 8'd3);
        mode = 2'b01;
        run_cap(2'd2, 8'd1);
        mode = 2'b00;
        i_host.xfer(16'h8a1c, r);
        i_host.xfer(16'h8b03, r);
        check("index", 16'h031c, {4'h0, buf_index});
        i_host.xfer(16'h1200, r);
        check("advance", 16'h031d, {4'h0, buf_index});
        i_host.xfer(16'h0000, r);
        check("outbuf", 16'ha31c, r);
        idx(12'h7ff, 2'b00, 12'h000);
        idx(12'hfff, 2'b10, 12'h000);
        idx(12'h7ff, 2'b10, 12'h800);
        supply_code = 12'h123;
        cap_start = 1'b1;
        @(negedge core_clk);
        cap_start = 1'b0;
        repeat (20) @(negedge core_clk);
        supply_code = 12'h456;
        cap_done = 1'b1;
        @(negedge core_clk);
        cap_done = 1'b0;
        repeat (3) @(negedge core_clk);
        check("tindex", 16'h0000, {4'h0, buf_index});
        rd(16'h0400, r);
        check("tsupply", 16'h0123, r);
        // Reset once the time capture has ended must bring back the power-on values
        rst = 1'b1;
        repeat (2) @(negedge core_clk);
        rst = 1'b0;
        check("rindex", 16'h0000, {4'h0, buf_index});
        check("rcount", 16'h0001, {8'h00, avg_count});
        repeat (4) @(negedge core_clk);
        rd(16'h0400, r);
        check("rsupply", 16'h8000, r);
        report_and_stop;
    end
endmodule // test_spectral_avg_regs
